// file: rtl/fcp_check.sv
// combinational verdict on one flash command
`timescale 1ns/1ps
`default_nettype none
module fcp_check
   import fcp_pkg::*;
#(
   parameter int BLK_SHIFT = BLK_SHIFT_DEF
)(
   fcp_chk_if.chk c
);
   // highest numbered block, the array's last block cut to BLK_W bits
   localparam logic [BLK_W-1:0] MAX_BLK =
      BLK_W'((1 << (ADDR_W - BLK_SHIFT)) - 1);
   // block numbers reach the whole array only for large enough blocks
   localparam logic ALL_BLK = (ADDR_W - BLK_SHIFT <= BLK_W);

   logic [ADDR_W-1:0] shifted;   // address moved down to block number
   logic [BLK_W-1:0]  blk;       // target block
   logic              in_boot;   // target inside the boot area
   logic              in_win;    // target inside the window
   logic              full_win;  // window spans the whole array
   logic              ext;       // command from external programming

   // decide allow and reason, boot check first for write and erase ops
   always_comb
   begin
      shifted  = c.addr >> BLK_SHIFT;
      blk      = shifted[BLK_W-1:0];
      in_boot  = (c.addr >= BOOT_LO) && (c.addr <= BOOT_HI);
      // an address past the last numbered block never aliases inward
      in_win   = (shifted[ADDR_W-1:BLK_W] == '0) &&
                 (blk >= c.win_lo) && (blk <= c.win_hi);
      full_win = ALL_BLK && (c.win_lo == '0) && (c.win_hi == MAX_BLK);
      ext      = c.src_ext;
      c.allow  = 1'b0;
      c.err    = ERR_OP;
      unique case (c.op)
         OP_WRITE:
         begin
            if (c.act[PB_BOOT] && in_boot)
               c.err = ERR_BOOT;
            else if (ext && c.act[PB_WR])
               c.err = ERR_SEC;
            else if (!ext && !in_win)
               c.err = ERR_WIN;
            else
            begin
               c.allow = 1'b1;
               c.err   = ERR_NONE;
            end
         end
         OP_BLK:
         begin
            if (c.act[PB_BOOT] && in_boot)
               c.err = ERR_BOOT;
            else if (ext && (c.act[PB_CHIP] || c.act[PB_BLK] ||
                             c.act[PB_WR]))
               c.err = ERR_SEC;
            else if (!ext && !in_win)
               c.err = ERR_WIN;
            else
            begin
               c.allow = 1'b1;
               c.err   = ERR_NONE;
            end
         end
         OP_CHIP:
         begin
            if (c.act[PB_BOOT])                  // whole array holds boot
               c.err = ERR_BOOT;
            else if (ext && c.act[PB_CHIP])
               c.err = ERR_SEC;
            else if (!ext && !full_win)
               c.err = ERR_WIN;
            else
            begin
               c.allow = 1'b1;
               c.err   = ERR_NONE;
            end
         end
         OP_SEC:
         begin
            // once frozen, no set bit may be cleared
            if (c.stored[PB_CHIP] &&
                ((c.data[PROH_W-1:0] & c.stored) != c.stored))
               c.err = ERR_LOCK;
            else
            begin
               c.allow = 1'b1;                   // either source
               c.err   = ERR_NONE;
            end
         end
         OP_WIN:
         begin
            // bounds from either source, start not above end
            if (c.data[BLK_W-1:0] > c.data[WIN_HI_POS +: BLK_W])
               c.err = ERR_OP;
            else
            begin
               c.allow = 1'b1;
               c.err   = ERR_NONE;
            end
         end
         default:
         begin
            c.allow = 1'b0;                      // unknown op
            c.err   = ERR_OP;
         end
      endcase
   end
endmodule : fcp_check
`default_nettype wire

// file: rtl/fcp_chk_if.sv
// carrier between the command front end and the protection checker
`timescale 1ns/1ps
`default_nettype none
interface fcp_chk_if;
   import fcp_pkg::*;
   fcp_op_t                 op;       // operation under test
   logic                    src_ext;  // 1: external programmer
   logic [ADDR_W-1:0]       addr;     // target address
   logic [DATA_W-1:0]       data;     // settings or bounds asked for
   logic [PROH_W-1:0]       act;      // applied prohibitions
   logic [PROH_W-1:0]       stored;   // stored prohibitions
   logic [BLK_W-1:0]        win_lo;   // window start block
   logic [BLK_W-1:0]        win_hi;   // window end block
   logic                    allow;    // verdict
   logic [ERR_W-1:0]        err;      // reason for refusal
   modport req (output op, src_ext, addr, data, act, stored, win_lo,
                win_hi, input allow, err);
   modport chk (input op, src_ext, addr, data, act, stored, win_lo,
                win_hi, output allow, err);
endinterface : fcp_chk_if
`default_nettype wire

// file: rtl/fcp_pkg.sv
// shared constants and types for the flash command protection block
package fcp_pkg;
   // flash address and block geometry
   localparam int ADDR_W        = 20;          // flash byte address width
   localparam int BLK_W         = 8;           // block number width
   localparam int BLK_SHIFT_DEF = 10;          // default block size 1 KB
   localparam int DATA_W        = 16;          // command data width
   localparam int BYTE_W        = 8;           // flash write data width
   // boot area bounds
   localparam logic [ADDR_W-1:0] BOOT_LO = 20'h00000;
   localparam logic [ADDR_W-1:0] BOOT_HI = 20'h00fff;
   // prohibition bit positions
   localparam int PB_CHIP = 0;                 // chip erase prohibited
   localparam int PB_BLK  = 1;                 // block erase prohibited
   localparam int PB_WR   = 2;                 // write prohibited
   localparam int PB_BOOT = 3;                 // boot area rewrite prohibited
   localparam int PROH_W  = 4;
   localparam logic [PROH_W-1:0] PROH_SHIP = 4'h0;  // shipped state
   // register port
   localparam int REG_AW = 4;
   localparam int REG_DW = 32;
   localparam logic [REG_AW-1:0] REG_MODE   = 4'h0;  // write: enter mode
   localparam logic [REG_AW-1:0] REG_ACT    = 4'h1;  // applied settings
   localparam logic [REG_AW-1:0] REG_STORED = 4'h2;  // stored settings
   localparam logic [REG_AW-1:0] REG_WIN    = 4'h3;  // window bounds
   localparam logic [REG_AW-1:0] REG_STAT   = 4'h4;  // last error, rejects
   localparam int MODE_ENTER_BIT = 0;
   localparam int WIN_HI_POS     = 8;          // window high in data
   localparam int STAT_CNT_POS   = 8;          // reject count in status
   localparam int CNT_W          = 8;
   // command operations
   typedef enum logic [2:0] {
      OP_WRITE = 3'b000,
      OP_BLK   = 3'b001,
      OP_CHIP  = 3'b010,
      OP_SEC   = 3'b011,
      OP_WIN   = 3'b100
   } fcp_op_t;
   // answer codes
   localparam int ERR_W = 3;
   localparam logic [ERR_W-1:0] ERR_NONE = 3'h0;
   localparam logic [ERR_W-1:0] ERR_SEC  = 3'h1;   // prohibition hit
   localparam logic [ERR_W-1:0] ERR_BOOT = 3'h2;   // boot area locked
   localparam logic [ERR_W-1:0] ERR_WIN  = 3'h3;   // outside window
   localparam logic [ERR_W-1:0] ERR_LOCK = 3'h4;   // settings frozen
   localparam logic [ERR_W-1:0] ERR_OP   = 3'h5;   // bad op or bounds
endpackage : fcp_pkg

// file: rtl/fcp_top.sv
// flash command protection: settings storage, gating and register port
`timescale 1ns/1ps
`default_nettype none
module fcp_top
   import fcp_pkg::*;
#(
   parameter int BLK_SHIFT = BLK_SHIFT_DEF     // log2 of block size
)(
   input  wire logic                ref_clk,
   input  wire logic                reset,
   input  wire logic                nv_init,
   input  wire logic [REG_AW-1:0]   reg_addr,
   input  wire logic [REG_DW-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [REG_DW-1:0]   reg_rdata,
   input  wire logic                cmd_valid,
   input  wire logic [2:0]          cmd_op,
   input  wire logic                cmd_src_ext,
   input  wire logic [ADDR_W-1:0]   cmd_addr,
   input  wire logic [DATA_W-1:0]   cmd_data,
   output logic                     rsp_valid,
   output logic                     rsp_err,
   output logic      [ERR_W-1:0]    rsp_code,
   output logic                     flash_wr,
   output logic                     flash_blk_erase,
   output logic                     flash_chip_erase,
   output logic      [ADDR_W-1:0]   flash_addr,
   output logic      [BYTE_W-1:0]   flash_wdata
);
   // refuse block sizes the checker cannot serve; addresses past the
   // last numbered block lie outside every window
   if (BLK_SHIFT < 1 || BLK_SHIFT > 12)
   begin : g_bad_shift
      $error("fcp_top: BLK_SHIFT out of range");
   end

   localparam logic [BLK_W-1:0] MAX_BLK =
      BLK_W'((1 << (ADDR_W - BLK_SHIFT)) - 1);

   // nonvolatile settings, untouched by reset
   logic [PROH_W-1:0] stored_r, stored_nxt;    // stored prohibitions
   logic [BLK_W-1:0]  win_lo_r, win_lo_nxt;    // window start block
   logic [BLK_W-1:0]  win_hi_r, win_hi_nxt;    // window end block
   // volatile state
   logic [PROH_W-1:0] act_r, act_nxt;          // applied prohibitions
   logic              rsp_valid_r, rsp_valid_nxt;
   logic              rsp_err_r, rsp_err_nxt;
   logic [ERR_W-1:0]  rsp_code_r, rsp_code_nxt;
   logic [ERR_W-1:0]  last_err_r, last_err_nxt;
   logic [CNT_W-1:0]  rej_cnt_r, rej_cnt_nxt;  // refused commands
   logic              fwr_r, fwr_nxt;
   logic              fbe_r, fbe_nxt;
   logic              fce_r, fce_nxt;
   logic [ADDR_W-1:0] faddr_r, faddr_nxt;
   logic [BYTE_W-1:0] fdata_r, fdata_nxt;
   logic [REG_DW-1:0] rdata_r, rdata_nxt;
   // decoded strobes
   logic              mode_enter;              // mode register written
   logic              go;                      // command allowed now
   logic              chip_go;                 // chip erase executes

   fcp_chk_if chk_if ();

   // present the command and current settings to the checker
   assign chk_if.op      = fcp_op_t'(cmd_op);
   assign chk_if.src_ext = cmd_src_ext;
   assign chk_if.addr    = cmd_addr;
   assign chk_if.data    = cmd_data;
   assign chk_if.act     = act_r;
   assign chk_if.stored  = stored_r;
   assign chk_if.win_lo  = win_lo_r;
   assign chk_if.win_hi  = win_hi_r;

   // verdict logic
   fcp_check #(
      .BLK_SHIFT (BLK_SHIFT)
   ) u_check (
      .c         (chk_if.chk)
   );

   // is this op code the wanted operation
   function automatic logic is_op(input logic [2:0] op,
                                  input fcp_op_t want);
      is_op = (op == want);
   endfunction : is_op

   assign mode_enter = reg_wr && (reg_addr == REG_MODE) &&
                       reg_wdata[MODE_ENTER_BIT];
   assign go         = cmd_valid && chk_if.allow;
   assign chip_go    = go && is_op(cmd_op, OP_CHIP);

   // next values of the nonvolatile settings
   always_comb
   begin
      stored_nxt = stored_r;
      win_lo_nxt = win_lo_r;
      win_hi_nxt = win_hi_r;
      if (nv_init)
      begin
         stored_nxt = PROH_SHIP;               // shipped, all off
         win_lo_nxt = '0;
         win_hi_nxt = MAX_BLK;
      end
      else if (chip_go)
         stored_nxt = PROH_SHIP;               // chip erase clears
      else if (go && is_op(cmd_op, OP_SEC))
         stored_nxt = cmd_data[PROH_W-1:0];    // each bit its own
      else if (go && is_op(cmd_op, OP_WIN))
      begin
         win_lo_nxt = cmd_data[BLK_W-1:0];
         win_hi_nxt = cmd_data[WIN_HI_POS +: BLK_W];
      end
   end

   // nonvolatile storage, deliberately not reset
   always_ff @(posedge ref_clk)
   begin
      stored_r <= stored_nxt;
      win_lo_r <= win_lo_nxt;
      win_hi_r <= win_hi_nxt;
   end

   // next values of the applied settings, answer and flash strobes
   always_comb
   begin
      act_nxt       = act_r;
      rsp_valid_nxt = cmd_valid;
      rsp_err_nxt   = cmd_valid && !chk_if.allow;
      rsp_code_nxt  = cmd_valid ? chk_if.err : ERR_NONE;
      last_err_nxt  = last_err_r;
      rej_cnt_nxt   = rej_cnt_r;
      fwr_nxt       = go && is_op(cmd_op, OP_WRITE);
      fbe_nxt       = go && is_op(cmd_op, OP_BLK);
      fce_nxt       = chip_go;
      faddr_nxt     = faddr_r;
      fdata_nxt     = fdata_r;
      if (go)
      begin
         faddr_nxt = cmd_addr;
         fdata_nxt = cmd_data[BYTE_W-1:0];
      end
      // refused: no flash strobe, error answered
      if (cmd_valid && !chk_if.allow)
      begin
         last_err_nxt = chk_if.err;
         if (rej_cnt_r != '1)
            rej_cnt_nxt = rej_cnt_r + 1'b1;
      end
      // stored settings take hold on mode entry; an allowed chip erase clears them and wins
      if (chip_go)
         act_nxt = PROH_SHIP;
      else if (mode_enter)
         act_nxt = stored_r;
   end

   // register the volatile state; reset re-enters with stored settings
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         act_r       <= stored_r;
         rsp_valid_r <= 1'b0;
         rsp_err_r   <= 1'b0;
         rsp_code_r  <= ERR_NONE;
         last_err_r  <= ERR_NONE;
         rej_cnt_r   <= '0;
         fwr_r       <= 1'b0;
         fbe_r       <= 1'b0;
         fce_r       <= 1'b0;
         faddr_r     <= '0;
         fdata_r     <= '0;
      end
      else
      begin
         act_r       <= act_nxt;
         rsp_valid_r <= rsp_valid_nxt;
         rsp_err_r   <= rsp_err_nxt;
         rsp_code_r  <= rsp_code_nxt;
         last_err_r  <= last_err_nxt;
         rej_cnt_r   <= rej_cnt_nxt;
         fwr_r       <= fwr_nxt;
         fbe_r       <= fbe_nxt;
         fce_r       <= fce_nxt;
         faddr_r     <= faddr_nxt;
         fdata_r     <= fdata_nxt;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb
   begin
      rdata_nxt = '0;
      if (reg_rd)
      begin
         unique case (reg_addr)
            REG_ACT:    rdata_nxt[PROH_W-1:0] = act_r;
            REG_STORED: rdata_nxt[PROH_W-1:0] = stored_r;
            REG_WIN:
            begin
               rdata_nxt[BLK_W-1:0]           = win_lo_r;
               rdata_nxt[WIN_HI_POS +: BLK_W] = win_hi_r;
            end
            REG_STAT:
            begin
               rdata_nxt[ERR_W-1:0]            = last_err_r;
               rdata_nxt[STAT_CNT_POS +: CNT_W] = rej_cnt_r;
            end
            default:    rdata_nxt = '0;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         rdata_r <= '0;
      else
         rdata_r <= rdata_nxt;
   end

   assign reg_rdata        = rdata_r;
   assign rsp_valid        = rsp_valid_r;
   assign rsp_err          = rsp_err_r;
   assign rsp_code         = rsp_code_r;
   assign flash_wr         = fwr_r;
   assign flash_blk_erase  = fbe_r;
   assign flash_chip_erase = fce_r;
   assign flash_addr       = faddr_r;
   assign flash_wdata      = fdata_r;

   // applied settings move only on reset, mode entry or chip erase
   a_act_hold: assert property (@(posedge ref_clk) disable iff (reset)
      ($past(reset) == 1'b0 && !$past(mode_enter) && !fce_r)
      |-> act_r == $past(act_r))
      else $error("applied settings changed without mode entry");

   // external chip erase refused under chip-erase lock
   a_ext_chip: assert property (@(posedge ref_clk) disable iff (reset)
      (cmd_valid && cmd_src_ext && act_r[PB_CHIP] &&
       cmd_op inside {OP_BLK, OP_CHIP})
      |=> rsp_err && !flash_blk_erase && !flash_chip_erase)
      else $error("erase passed under chip-erase lock");

   // frozen settings lose no bit except by chip erase or factory init
   a_lock_keep: assert property (@(posedge ref_clk)
      (stored_r[PB_CHIP] && !nv_init && !chip_go)
      |=> (stored_r & $past(stored_r)) == $past(stored_r))
      else $error("frozen setting was cleared");

   // external block erase refused under block-erase lock
   a_blk_ext: assert property (@(posedge ref_clk) disable iff (reset)
      (cmd_valid && cmd_src_ext && act_r[PB_BLK] && is_op(cmd_op, OP_BLK))
      |=> rsp_err && (rsp_code == ERR_SEC || rsp_code == ERR_BOOT))
      else $error("external block erase passed under lock");

   // self block erase in window, unlocked boot, goes through
   a_self_blk: assert property (@(posedge ref_clk) disable iff (reset)
      (cmd_valid && !cmd_src_ext && is_op(cmd_op, OP_BLK) &&
       !act_r[PB_BOOT] && chk_if.allow)
      |=> flash_blk_erase && flash_addr == $past(cmd_addr))
      else $error("allowed self block erase did not strobe");

   // external write refused under write lock
   a_wr_ext: assert property (@(posedge ref_clk) disable iff (reset)
      (cmd_valid && cmd_src_ext && act_r[PB_WR] &&
       cmd_op inside {OP_WRITE, OP_BLK})
      |=> rsp_err && !flash_wr && !flash_blk_erase)
      else $error("external write passed under write lock");

   // boot area untouched under boot lock, whatever the window
   a_boot_wr: assert property (@(posedge ref_clk) disable iff (reset)
      (cmd_valid && act_r[PB_BOOT] && cmd_addr <= BOOT_HI &&
       cmd_op inside {OP_WRITE, OP_BLK, OP_CHIP})
      |=> rsp_code == ERR_BOOT)
      else $error("boot area rewrite not refused");

   // allowed chip erase clears stored and applied settings
   a_chip_clr: assert property (@(posedge ref_clk) disable iff (reset)
      chip_go |=> stored_r == PROH_SHIP && act_r == PROH_SHIP)
      else $error("chip erase left a setting active");

   // self programming outside window refused
   a_win_self: assert property (@(posedge ref_clk) disable iff (reset)
      (cmd_valid && !cmd_src_ext && cmd_op inside {OP_WRITE, OP_BLK} &&
       !act_r[PB_BOOT] &&
       (BLK_W'(cmd_addr >> BLK_SHIFT) < win_lo_r ||
        BLK_W'(cmd_addr >> BLK_SHIFT) > win_hi_r))
      |=> rsp_code == ERR_WIN)
      else $error("self command outside window not refused");

   // refused command makes no flash strobe and answers once
   a_rej_quiet: assert property (@(posedge ref_clk) disable iff (reset)
      (cmd_valid && !chk_if.allow)
      |=> rsp_valid && rsp_err &&
          !(flash_wr || flash_blk_erase || flash_chip_erase)
          ##1 !rsp_err || $past(cmd_valid))
      else $error("refused command touched the flash");

   // factory init clears stored settings and window start
   a_ship_off: assert property (@(posedge ref_clk)
      nv_init |=> stored_r == PROH_SHIP && win_lo_r == '0)
      else $error("factory init left a setting on");
endmodule : fcp_top
`default_nettype wire

// file: tb/fcp_prog_model.sv
// command source model: external programmer or self-programming firmware
`timescale 1ns/1ps
`default_nettype none
module fcp_prog_model
   import fcp_pkg::*;
(
   input  wire logic              ref_clk,
   output logic                   cmd_valid,
   output logic [2:0]             cmd_op,
   output logic                   cmd_src_ext,
   output logic [ADDR_W-1:0]      cmd_addr,
   output logic [DATA_W-1:0]      cmd_data
);
   // idle at start: no command offered
   initial
   begin
      cmd_valid   = 1'b0;
      cmd_op      = 3'h7;
      cmd_src_ext = 1'b0;
      cmd_addr    = 20'h00000;
      cmd_data    = 16'h0000;
   end
   // one command pulse; op, address and data scrambled after it so stale values never match
   task automatic send(input logic [2:0] op, input logic ext,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      cmd_valid   <= 1'b1;
      cmd_op      <= op;
      cmd_src_ext <= ext;
      cmd_addr    <= a;
      cmd_data    <= d;
      @(posedge ref_clk);
      cmd_valid   <= 1'b0;
      cmd_op      <= ~op;
      cmd_addr    <= ~a;
      cmd_data    <= ~d;
      #1;
   endtask : send
endmodule : fcp_prog_model
`default_nettype wire

// file: tb/fcp_top_tb_top.sv
// self-checking bench for the flash command protection block
`timescale 1ns/1ps
`default_nettype none
module fcp_top_tb_top
   import fcp_pkg::*;
;
   logic ref_clk, reset, nv_init, reg_wr, reg_rd;
   logic [REG_AW-1:0] reg_addr;
   logic [REG_DW-1:0] reg_wdata, reg_rdata;
   logic cmd_valid, cmd_src_ext, rsp_valid, rsp_err;
   logic [2:0] cmd_op;
   logic [ADDR_W-1:0] cmd_addr, flash_addr;
   logic [DATA_W-1:0] cmd_data;
   logic [ERR_W-1:0] rsp_code;
   logic flash_wr, flash_blk_erase, flash_chip_erase;
   logic [BYTE_W-1:0] flash_wdata;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] exp_rej = 8'h00;           // refusals expected so far
   // block under test
   fcp_top #(.BLK_SHIFT(10)) uut (.ref_clk(ref_clk), .reset(reset),
      .nv_init(nv_init), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_src_ext(cmd_src_ext),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
      .rsp_err(rsp_err), .rsp_code(rsp_code), .flash_wr(flash_wr),
      .flash_blk_erase(flash_blk_erase), .flash_chip_erase(flash_chip_erase),
      .flash_addr(flash_addr), .flash_wdata(flash_wdata));
   // command source on the far side
   fcp_prog_model u_prog (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_src_ext(cmd_src_ext), .cmd_addr(cmd_addr),
      .cmd_data(cmd_data));
   // 200 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // closing report, reached once
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   // hang guard: run needs about 170 cycles
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_total++;
         tally_and_finish();
      end
   end
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // register write: one strobe cycle
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr_reg
   // register read, data taken in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, exp);
      @(posedge ref_clk);
      #1;
      chk(reg_rdata, 32'h0);              // read data stands one cycle
   endtask : rd_chk
   // one command and its answer; strobes only on an allowed flash op
   task automatic cmd(input logic [2:0] op, input logic ext,
      input logic [19:0] a, input logic [15:0] d, input logic [2:0] code);
      logic ok;
      ok = (code === ERR_NONE);
      u_prog.send(op, ext, a, d);
      chk({24'h0, rsp_valid, rsp_err, rsp_code, flash_wr, flash_blk_erase,
         flash_chip_erase}, {24'h0, 1'b1, !ok, code, ok && op == 3'h0,
         ok && op == 3'h1, ok && op == 3'h2});
      if (ok && op == 3'h0)
         chk({4'h0, flash_addr, flash_wdata}, {4'h0, a, d[7:0]});
      // answer and strobes stand one cycle only
      @(posedge ref_clk);
      #1;
      chk({26'h0, rsp_valid, rsp_err, rsp_code,
         flash_wr | flash_blk_erase | flash_chip_erase}, 32'h0);
      if (!ok)
         exp_rej++;
   endtask : cmd
   // main sequence
   initial
   begin
      {reset, nv_init} = 2'h3;
      {reg_wr, reg_rd} = 2'h0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      repeat (20) @(posedge ref_clk);
      nv_init <= 1'b0;
      reset   <= 1'b0;
      rd_chk(REG_ACT, 32'h0);
      rd_chk(REG_STORED, 32'h0);
      rd_chk(REG_WIN, 32'h0000ff00);
      cmd(OP_WRITE, 1'b1, 20'h00010, 16'h005a, ERR_NONE);
      cmd(OP_SEC, 1'b1, 20'h0, 16'h0004, ERR_NONE);
      cmd(OP_WRITE, 1'b1, 20'h10000, 16'h00a5, ERR_NONE);
      wr_reg(REG_MODE, 32'h1);
      cmd(OP_WRITE, 1'b1, 20'h10000, 16'h00a5, ERR_SEC);
      cmd(OP_BLK, 1'b1, 20'h10000, 16'h0, ERR_SEC);
      cmd(OP_WRITE, 1'b0, 20'h10000, 16'h0033, ERR_NONE);
      $display("test write lock done");
      cmd(OP_SEC, 1'b0, 20'h0, 16'h0002, ERR_NONE);
      wr_reg(REG_MODE, 32'h1);
      rd_chk(REG_ACT, 32'h2);
      cmd(OP_BLK, 1'b1, 20'h10000, 16'h0, ERR_SEC);
      cmd(OP_WRITE, 1'b1, 20'h10000, 16'h0011, ERR_NONE);
      cmd(OP_BLK, 1'b0, 20'h10000, 16'h0, ERR_NONE);
      $display("test block lock done");
      cmd(OP_WIN, 1'b0, 20'h0, 16'h0604, ERR_NONE);
      rd_chk(REG_WIN, 32'h00000604);
      cmd(OP_WRITE, 1'b0, 20'h01400, 16'h0077, ERR_NONE);
      cmd(OP_WRITE, 1'b0, 20'h01bff, 16'h0078, ERR_NONE);
      cmd(OP_WRITE, 1'b0, 20'h01c00, 16'h0079, ERR_WIN);
      cmd(OP_BLK, 1'b0, 20'h00fff, 16'h0, ERR_WIN);
      cmd(OP_WRITE, 1'b1, 20'h01c00, 16'h007a, ERR_NONE);
      cmd(OP_WIN, 1'b1, 20'h0, 16'h0306, ERR_OP);
      cmd(3'h7, 1'b1, 20'h0, 16'h0, ERR_OP);
      cmd(OP_WIN, 1'b1, 20'h0, 16'h0600, ERR_NONE);
      cmd(OP_WRITE, 1'b0, 20'h40400, 16'h0012, ERR_WIN);
      $display("test window done");
      cmd(OP_SEC, 1'b1, 20'h0, 16'h000a, ERR_NONE);
      wr_reg(REG_MODE, 32'h1);
      cmd(OP_WRITE, 1'b0, 20'h00800, 16'h0055, ERR_BOOT);
      cmd(OP_WRITE, 1'b1, 20'h00fff, 16'h0055, ERR_BOOT);
      cmd(OP_WRITE, 1'b1, 20'h01000, 16'h0056, ERR_NONE);
      cmd(OP_CHIP, 1'b1, 20'h0, 16'h0, ERR_BOOT);
      rd_chk(REG_STAT, {16'h0, exp_rej, 5'h0, ERR_BOOT});
      $display("test boot lock done");
      cmd(OP_SEC, 1'b1, 20'h0, 16'h0002, ERR_NONE);
      wr_reg(REG_MODE, 32'h1);
      cmd(OP_CHIP, 1'b0, 20'h0, 16'h0, ERR_WIN);
      cmd(OP_CHIP, 1'b1, 20'h0, 16'h0, ERR_NONE);
      rd_chk(REG_STORED, 32'h0);
      rd_chk(REG_ACT, 32'h0);
      cmd(OP_SEC, 1'b0, 20'h0, 16'h0001, ERR_NONE);
      wr_reg(REG_MODE, 32'h1);
      cmd(OP_BLK, 1'b1, 20'h10000, 16'h0, ERR_SEC);
      cmd(OP_CHIP, 1'b1, 20'h0, 16'h0, ERR_SEC);
      cmd(OP_SEC, 1'b1, 20'h0, 16'h0000, ERR_LOCK);
      cmd(OP_SEC, 1'b1, 20'h0, 16'h0003, ERR_NONE);
      $display("test chip lock done");
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      rd_chk(REG_STORED, 32'h3);
      rd_chk(REG_WIN, 32'h00000600);
      rd_chk(REG_ACT, 32'h3);
      rd_chk(REG_STAT, 32'h0);
      $display("test reset persistence done");
      tally_and_finish();
   end
endmodule : fcp_top_tb_top
`default_nettype wire
